// [svw_cpu_model.sv]
// processor model: strobes the watchdog and obeys the reset line
`timescale 1ns/1ps
module svw_cpu_model (
    input  wire logic        clk,       // logic clock
    input  wire logic        resetN,    // reset from the supervisor
    input  wire logic        strobeOn,  // strobing enabled by the bench
    input  wire logic        ignoreRst, // keep strobing inside reset too
    input  wire logic [15:0] period,    // cycles between toggles
    output logic             strobeOut  // watchdog strobe
);
    logic [15:0] cnt;  // cycles since the last toggle

    initial strobeOut = 1'b0;
    initial cnt = 16'h0;
    // a processor held in reset runs no code, so its count restarts there,
    // unless the bench wants edges inside the pulse
    always @(posedge clk) begin
        if ((!resetN && !ignoreRst) || !strobeOn) begin
            cnt <= 16'h0;
        end else if (cnt >= period - 16'h1) begin
            cnt       <= 16'h0;
            strobeOut <= ~strobeOut;
        end else begin
            cnt <= cnt + 16'h1;
        end
    end
endmodule : svw_cpu_model

// [svw_edge_sync.sv]
// strobe synchroniser and two-edge detector
`timescale 1ns/1ps
module svw_edge_sync (
    input  wire logic clk,      // logic clock
    input  wire logic nrst,     // async reset, low active
    input  wire logic strobeIn, // raw strobe from the processor
    output logic      edgeSeen  // one-cycle pulse on either edge
);
    logic s1Reg;                // first stage, read only by s2Reg
    logic s2Reg;                // second stage
    logic s3Reg;                // delayed copy for edge compare

    // two-flop sync then compare stages two and three
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1Reg    <= 1'b0;
            s2Reg    <= 1'b0;
            s3Reg    <= 1'b0;
            edgeSeen <= 1'b0;
        end else begin
            s1Reg    <= strobeIn;
            s2Reg    <= s1Reg;
            s3Reg    <= s2Reg;
            edgeSeen <= s2Reg ^ s3Reg; // rising or falling
        end
    end
endmodule : svw_edge_sync

// [svw_hold_ctrl.sv]
// enable, self-hold and thermal cycling of the regulator output
`timescale 1ns/1ps
module svw_hold_ctrl (
    input  wire logic clk,            // logic clock
    input  wire logic nrst,           // async reset, low active
    input  wire logic onRequest,      // enable input
    input  wire logic holdN,          // self-hold, low holds
    input  wire logic overTemp,       // above upper threshold
    input  wire logic belowLowTemp,   // under lower threshold
    output logic      passOn          // pass element drive
);
    logic requestedReg;               // regulator logically on
    logic thermalOffReg;              // thermal shutdown latched

    // on with enable; stays on while hold low; hold release turns off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            requestedReg <= 1'b0;
        end else if (onRequest) begin
            requestedReg <= 1'b1;
        end else if (holdN) begin
            requestedReg <= 1'b0;            // hold high: plain switch
        end
    end

    // hysteretic thermal cycling
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            thermalOffReg <= 1'b0;
        end else if (overTemp) begin
            thermalOffReg <= 1'b1;
        end else if (belowLowTemp) begin
            thermalOffReg <= 1'b0;           // back on only below lower point
        end
    end

    // registered drive of the pass element
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            passOn <= 1'b0;
        end else begin
            passOn <= requestedReg & ~thermalOffReg & ~overTemp;
        end
    end
endmodule : svw_hold_ctrl

// [svw_monitor.sv]
// property checker on the supervisor top ports
`timescale 1ns/1ps
module svw_monitor (
    input wire logic        clk,                 // logic clock
    input wire logic        nrst,                // async reset, low active
    input wire logic        supplyGood,          // output above threshold
    input wire logic        dogOffN,             // low stops the watchdog
    input wire logic        regulatorOnRequest,  // enable input
    input wire logic        holdN,               // self-hold, low holds
    input wire logic        overTemp,            // thermal shutdown
    input wire logic        belowLowTemp,        // thermal restart
    input wire logic        regWr,               // write strobe
    input wire logic        regRd,               // read strobe
    input wire logic [31:0] regRdata,            // read data
    input wire logic        resetN,              // reset output, low active
    input wire logic        primarySupplyOutput  // pass element drive
);
    // one clock domain, so clocking and disable are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data without a read strobe");
    // every pulse is far longer than eight cycles in any setting used here
    AST_PULSE_MIN: assert property ($fell(resetN) |-> !resetN [*8])
        else $error("reset pulse cut short");
    AST_SUPPLY_LOW: assert property (!supplyGood |-> ##[1:2] !resetN)
        else $error("low supply did not assert reset");
    // writes may change the pulse select, so a quiet window after them is needed
    AST_DOG_QUIET: assert property ((!dogOffN && resetN && supplyGood && $past(supplyGood)
        && !regWr && !$past(regWr) && !$past(regWr, 2)) |=> resetN)
        else $error("reset fell with the watchdog off");
    AST_EN_ON: assert property (($rose(regulatorOnRequest) && !overTemp && belowLowTemp)
        |-> ##[1:3] primarySupplyOutput)
        else $error("enable did not turn the output on");
    AST_SELF_HOLD: assert property ((!holdN && primarySupplyOutput && !overTemp)
        |=> primarySupplyOutput)
        else $error("held output dropped");
    AST_HOLD_REL: assert property (($rose(holdN) && !regulatorOnRequest)
        |-> ##[1:2] !primarySupplyOutput)
        else $error("hold release left output on");
    AST_THERM_OFF: assert property (overTemp |-> ##[1:2] !primarySupplyOutput)
        else $error("over temperature left output on");
    AST_PLAIN_OFF: assert property ((holdN && !regulatorOnRequest) [*3]
        |-> !primarySupplyOutput)
        else $error("output on with enable low and no hold");
endmodule : svw_monitor

// [svw_pkg.sv]
// package for the supervisor watchdog and hold logic
package svw_pkg;
    localparam int    CLK_HZ          = 25000000;              // logic timebase
    localparam int    CNT_W           = 32;                    // width of every interval count
    localparam real   WDOG_FIXED_MS   = 280.0;                 // fixed watchdog timeout
    localparam int    WDOG_FIXED_CYC  = 7000000;               // 280 ms at 25 MHz
    localparam real   PULSE_FIXED_MS  = 200.0;                 // fixed reset pulse length
    localparam int    PULSE_FIXED_CYC = 5000000;               // 200 ms at 25 MHz
    localparam int    SUPPLY_GOOD_CYC = 1;                     // unused by the logic
    localparam logic [1:0] RATIO_8    = 2'h0;                  // sel_b,sel_a = 0,0
    localparam logic [1:0] RATIO_16   = 2'h2;                  // sel_b high
    localparam logic [1:0] RATIO_64   = 2'h3;                  // both high
    localparam logic [1:0] RATIO_OFF  = 2'h1;                  // sel_a high, sel_b low

    // pin selections for pulse length and timeout
    typedef enum logic [1:0] {
        SEL_FIXED  = 2'b00,                                    // tied to output
        SEL_ADJ    = 2'b01,                                    // programmed count
        SEL_GROUND = 2'b10                                     // tied to ground
    } svw_sel_t;

    // interval settings travelling together
    typedef struct packed {
        logic [CNT_W-1:0] pulseLen;                            // reset low length
        logic [CNT_W-1:0] slowLimit;                           // longest edge spacing
        logic [CNT_W-1:0] fastLimit;                           // shortest edge spacing
    } svw_limits_t;
endpackage : svw_pkg

// [svw_supervisor.sv]
// supervisor top: watchdog, reset pulse generator and register port
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
// one clock, one async reset; only the strobe
// needs a synchroniser, all else is synchronous
// Notes on behaviour
// - missed strobe edge within timeout asserts reset
// - no strobing gives repeating reset pulse train
// - reset held full length, strobes ignored
// - counter cleared by edge and reset
// - counter idle during reset, resumes after
// - window mode: too fast or slow resets
// - pulse length independent of timeout
// - enable turns on, hold low keeps on
// - hold release switches held output off
// - hold high: enable is plain switch
// - thermal off, on below lower threshold
// - pulse pin: fixed, adjustable, or stuck reset
// - low supply resets, then pulse after recovery
// - watchdog off input low disables watchdog
// - two selects choose ratio 8/16/64
// - sel_a high, sel_b low disables in window mode
module svw_supervisor
    import svw_pkg::*;
#(
    parameter int WDOG_DEF  = WDOG_FIXED_CYC,  // fixed timeout count
    parameter int PULSE_DEF = PULSE_FIXED_CYC  // fixed pulse count
) (
    input  wire logic        clk,          // 25 MHz clock
    input  wire logic        nrst,         // async reset, low active
    input  wire logic        strobeIn,     // watchdog strobe
    input  wire logic        supplyGood,   // output above threshold
    input  wire logic        dogOffN,      // low disables watchdog
    input  wire logic        windowRatioSelA, // ratio select a
    input  wire logic        windowRatioSelB, // ratio select b
    input  wire logic        regulatorOnRequest, // enable input
    input  wire logic        holdN,        // self-hold, low active
    input  wire logic        overTemp,     // above shutdown point
    input  wire logic        belowLowTemp, // below restart point
    input  wire logic [3:0]  regAddr,      // register word address
    input  wire logic [31:0] regWdata,     // write data
    input  wire logic        regWr,        // write strobe
    input  wire logic        regRd,        // read strobe
    output logic      [31:0] regRdata,     // read data, cycle after strobe
    output logic             resetN,       // reset output, low active
    output logic             primarySupplyOutput, // pass element drive
    output logic             irq           // level interrupt
);
    // software view: one word per address, no wait
    // states; unmapped words read zero, drop writes
    // register word addresses
    localparam logic [3:0] A_CTRL   = 4'h0; // [1:0] pulse sel, [3:2] timeout sel, [4] window
    localparam logic [3:0] A_PULSE  = 4'h1; // adjustable pulse length
    localparam logic [3:0] A_SLOW   = 4'h2; // adjustable slow limit
    localparam logic [3:0] A_STAT   = 4'h3; // sticky events, read only
    localparam logic [3:0] A_CLR    = 4'h4; // write one to clear
    localparam logic [3:0] A_IEN    = 4'h5; // interrupt enable
    localparam logic [3:0] A_STATE  = 4'h6; // live state
    // event bits: supply low, fast fault, slow fault
    localparam logic [4:0] CTRL_RST = 5'h00; // fixed settings, simple mode
    localparam int         EV_W     = 3;     // slow, fast, supply events

    // reset generator states; leaving ST_LOW always
    // passes through one full pulse, so reset is
    // never released before the pulse has ended
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,       // watching the strobe
        ST_PULSE = 2'b01,       // reset held low
        ST_LOW   = 2'b10        // supply low or pin grounded
    } svw_state_t;

    // registers, then terms derived from them
    svw_state_t       stateReg;   // reset generator state
    logic [4:0]       ctrlReg;    // control fields
    logic [CNT_W-1:0] pulseReg;   // programmed pulse count
    logic [CNT_W-1:0] slowReg;    // programmed slow count
    logic [EV_W-1:0]  statReg;    // sticky events
    logic [EV_W-1:0]  ienReg;     // interrupt enables
    logic [CNT_W-1:0] dogCntReg;  // watchdog interval counter
    logic [CNT_W-1:0] rstCntReg;  // reset pulse counter
    logic             edgeSeen;   // strobe edge pulse
    svw_limits_t      lim;        // active limits
    logic             dogOn;      // watchdog enabled
    logic             slowFault;  // timeout expired
    logic             fastFault;  // edge came too early
    logic             stuckLow;   // pulse pin grounded
    logic [EV_W-1:0]  events;     // this cycle's events

    // pick a count from its pin setting
    // the ground setting falls back to the fixed
    // count; its stuck reset is stuckLow's job
    function automatic logic [CNT_W-1:0] pickCount(input logic [1:0] sel,
                                                   input logic [CNT_W-1:0] fixed,
                                                   input logic [CNT_W-1:0] adj);
        pickCount = (sel == SEL_ADJ) ? adj : fixed;
    endfunction : pickCount

    // edges arrive three cycles late; every interval
    // is shifted alike, so lengths are unaffected
    svw_edge_sync u_sync (
        .clk      (clk),
        .nrst     (nrst),
        .strobeIn (strobeIn),
        .edgeSeen (edgeSeen)
    );

    // hold and thermal logic, apart from the watchdog
    svw_hold_ctrl u_hold (
        .clk          (clk),
        .nrst         (nrst),
        .onRequest    (regulatorOnRequest),
        .holdN        (holdN),
        .overTemp     (overTemp),
        .belowLowTemp (belowLowTemp),
        .passOn       (primarySupplyOutput)
    );

    // limits: pulse and timeout chosen separately
    // a shift stands in for a divider, as every
    // ratio is a power of two; a tiny slow limit
    // gives a fast limit of zero, never a fault
    always_comb begin
        lim.pulseLen  = pickCount(ctrlReg[1:0], CNT_W'(PULSE_DEF), pulseReg);
        lim.slowLimit = pickCount(ctrlReg[3:2], CNT_W'(WDOG_DEF), slowReg);
        // fast limit from the ratio selects
        case ({windowRatioSelB, windowRatioSelA})
            RATIO_8:  lim.fastLimit = lim.slowLimit >> 3;
            RATIO_16: lim.fastLimit = lim.slowLimit >> 4;
            RATIO_64: lim.fastLimit = lim.slowLimit >> 6;
            default:  lim.fastLimit = '0;
        endcase
        // simple mode: edges may come at any rate
        if (!ctrlReg[4]) begin
            lim.fastLimit = '0;                            // simple mode has no floor
        end
    end

    // watchdog enable from the off input and window selects
    // slowFault fires one count early so that the
    // registered output falls slowLimit cycles after
    // the counter starts; an edge in that same cycle
    // wins and the expiry is dropped
    assign dogOn     = dogOffN &&
                       !(ctrlReg[4] && {windowRatioSelB, windowRatioSelA} == RATIO_OFF);
    assign slowFault = dogOn && (dogCntReg >= lim.slowLimit - 1);
    assign fastFault = dogOn && edgeSeen && (dogCntReg < lim.fastLimit);
    assign stuckLow  = (ctrlReg[1:0] == SEL_GROUND);
    assign events    = {!supplyGood, fastFault, slowFault && !edgeSeen};

    // reset state machine
    // leaving ST_PULSE restarts the pulse count, so a
    // pulse cut by a supply drop is given in full
    // once the supply has recovered
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stateReg  <= ST_LOW;
            rstCntReg <= '0;
        end else begin
            case (stateReg)
                ST_RUN: begin
                    // count parked; supply loss outranks a fault
                    rstCntReg <= '0;
                    if (!supplyGood || stuckLow) begin
                        stateReg <= ST_LOW;
                    end else if (events[1] || events[0]) begin
                        stateReg <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    // strobe edges are not looked at here
                    // supply drop or grounded pin cuts it short
                    if (!supplyGood || stuckLow) begin
                        stateReg  <= ST_LOW;
                        rstCntReg <= '0;
                    end else if (rstCntReg >= lim.pulseLen - 1) begin
                        stateReg  <= ST_RUN;                 // pulse then high again
                        rstCntReg <= '0;
                    end else begin
                        rstCntReg <= rstCntReg + 1'b1;       // full length
                    end
                end
                ST_LOW: begin
                    // held while supply low or pin grounded
                    rstCntReg <= '0;
                    if (supplyGood && !stuckLow) begin
                        stateReg <= ST_PULSE;                // pulse after recovery
                    end
                end
                default: begin
                    // stray code: recover through a full pulse
                    stateReg  <= ST_LOW;
                    rstCntReg <= '0;
                end
            endcase
        end
    end

    // watchdog interval counter
    // only live in ST_RUN: any reset assertion clears
    // it and keeps it still until the release
    // with the watchdog off it stays at zero, so
    // turning it on starts a full interval
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dogCntReg <= '0;
        end else if (stateReg != ST_RUN || !dogOn) begin
            dogCntReg <= '0;                   // idle during reset
        end else if (edgeSeen || slowFault) begin
            dogCntReg <= '0;                   // cleared on edge or expiry
        end else begin
            dogCntReg <= dogCntReg + 1'b1;
        end
    end

    // registered reset output
    // fault terms are folded in so reset falls in
    // the cycle of the state change, not after it;
    // limitation: a one-cycle supply dip still
    // costs a full pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resetN <= 1'b0;
        end else begin
            resetN <= (stateReg == ST_RUN) && supplyGood && !stuckLow &&
                      !events[1] && !events[0];
        end
    end

    // software writes to control and limits
    // a zero count would underflow the compare, so
    // it is stored as one; a new pulse count also
    // applies to a pulse already running
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrlReg  <= CTRL_RST;
            pulseReg <= CNT_W'(PULSE_DEF);
            slowReg  <= CNT_W'(WDOG_DEF);
            ienReg   <= '0;
        end else if (regWr) begin
            // status, clear and state words store nothing
            case (regAddr)
                A_CTRL:  ctrlReg  <= regWdata[4:0];
                A_PULSE: pulseReg <= (regWdata == '0) ? 32'h1 : regWdata;
                A_SLOW:  slowReg  <= (regWdata == '0) ? 32'h1 : regWdata;
                A_IEN:   ienReg   <= regWdata[EV_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky status, set beats clear
    // an event in the cycle of its clear is kept;
    // faults are only logged in ST_RUN, where they
    // start a pulse; the supply bit is renewed
    // every cycle the supply is low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            statReg <= '0;
        end else begin
            statReg <= (statReg & ~((regWr && regAddr == A_CLR) ?
                        regWdata[EV_W-1:0] : {EV_W{1'b0}})) |
                       (events & {EV_W{stateReg == ST_RUN}}) |
                       {!supplyGood, 2'b00};
        end
    end

    // interrupt level
    // one cycle behind status so irq is a plain
    // flop; an enable written over a set bit
    // raises irq on the following cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(statReg & ienReg);
        end
    end

    // read data, valid only the cycle after a read strobe
    // zero outside the data cycle lets readers share
    // the bus through an or of their data; the clear
    // word reads zero, nothing stands behind it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= '0;
        end else if (regRd) begin
            case (regAddr)
                A_CTRL:  regRdata <= {27'h0, ctrlReg};
                A_PULSE: regRdata <= pulseReg;
                A_SLOW:  regRdata <= slowReg;
                A_STAT:  regRdata <= {29'h0, statReg};
                A_IEN:   regRdata <= {29'h0, ienReg};
                A_STATE: regRdata <= {28'h0, dogOn, resetN, stateReg};
                default: regRdata <= '0;           // unmapped and clear read zero
            endcase
        end else begin
            regRdata <= '0;
        end
    end
endmodule : svw_supervisor

// [testbench.sv]
// self-checking bench for the supervisor watchdog and hold logic
`timescale 1ns/1ps
module testbench;
    import svw_pkg::*;
    localparam int PULSE = 50;   // shortened fixed pulse count
    localparam int WDOG  = 200;  // shortened fixed timeout count
    logic        clk, nrst, strobeIn, supplyGood, dogOffN, selA, selB;  // design inputs
    logic        onReq, holdN, overTemp, belowLowTemp, regWr, regRd;    // design inputs
    logic [3:0]  regAddr;                                               // register address
    logic [31:0] regWdata, regRdata;                                    // register data
    logic        resetN, supplyOut, irq, strobeOn, ignoreRst;           // outputs, model control
    logic [15:0] period;                                                // model strobe period
    int          nMismatch, checkCount;                                 // verdict counters
    logic [1:0]  ratios [4] = '{RATIO_8, RATIO_16, RATIO_64, RATIO_OFF}; // window table

    svw_supervisor #(.WDOG_DEF(WDOG), .PULSE_DEF(PULSE)) dut_u (
        .clk(clk), .nrst(nrst), .strobeIn(strobeIn), .supplyGood(supplyGood),
        .dogOffN(dogOffN), .windowRatioSelA(selA), .windowRatioSelB(selB),
        .regulatorOnRequest(onReq), .holdN(holdN), .overTemp(overTemp),
        .belowLowTemp(belowLowTemp), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .resetN(resetN),
        .primarySupplyOutput(supplyOut), .irq(irq));
    svw_cpu_model cpu_u (.clk(clk), .resetN(resetN), .strobeOn(strobeOn),
        .ignoreRst(ignoreRst), .period(period), .strobeOut(strobeIn));

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmpWord
    // write: strobe lowered after the taking edge, one idle edge after
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask : wr
    // read: data only stands in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 cmpWord(regRdata, exp);
        @(posedge clk);
    endtask : rd
    // wait for reset at lvl, then time how long it stays there
    task automatic runLen(input logic lvl, input int lo, input int hi);
        int n;
        n = 0;
        while (resetN !== lvl && n < 9000) begin
            @(posedge clk);
            #1 n++;
        end
        n = 0;
        while (resetN === lvl && n < 9000) begin
            @(posedge clk);
            #1 n++;
        end
        cmpWord({31'h0, n >= lo && n <= hi}, 32'h1);
    endtask : runLen
    // whether reset sat at lvl in any of n cycles
    task automatic levelCount(input logic lvl, input int n, input logic exp);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge clk);
            #1 c += (resetN === lvl);
        end
        cmpWord({31'h0, c != 0}, {31'h0, exp});
    endtask : levelCount
    // let the registered output settle, then look at it
    task automatic outIs(input logic exp);
        repeat (3) @(posedge clk);
        #1 cmpWord({31'h0, supplyOut}, {31'h0, exp});
    endtask : outIs
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", nMismatch, checkCount);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // hang guard, well beyond the expected run length
    initial begin
        #(40 * 60000);
        nMismatch++;
        conclude();
    end

    // main sequence: timings, registers, window table, supply, hold
    initial begin
        {clk, nrst, selA, selB, onReq, overTemp, regWr, regRd, strobeOn, ignoreRst} = 10'h0;
        {supplyGood, dogOffN, holdN, belowLowTemp} = 4'hf;
        {regAddr, regWdata, period} = 52'h64;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        runLen(1'b0, PULSE, PULSE + 3);
        runLen(1'b1, WDOG - 5, WDOG + 6);
        runLen(1'b0, PULSE, PULSE + 3);
        runLen(1'b1, WDOG - 5, WDOG + 6);
        strobeOn  <= 1'b1;
        ignoreRst <= 1'b1;                  // edges keep coming inside the pulse
        period    <= 16'h14;
        runLen(1'b0, PULSE, PULSE + 3);
        levelCount(1'b0, 1000, 1'b0);
        wr(4'h1, 32'h1e);
        wr(4'h2, 32'h78);
        wr(4'h0, 32'h5);                    // adjustable pulse and timeout
        rd(4'h1, 32'h1e);
        rd(4'h2, 32'h78);
        rd(4'hf, 32'h0);
        strobeOn  <= 1'b0;
        ignoreRst <= 1'b0;
        runLen(1'b1, 100, 126);
        runLen(1'b0, 30, 33);
        wr(4'h1, 32'h28);
        runLen(1'b1, 115, 126);
        runLen(1'b0, 40, 43);
        dogOffN <= 1'b0;
        levelCount(1'b0, 600, 1'b0);
        dogOffN <= 1'b1;
        strobeOn <= 1'b1;
        period <= 16'hc;                    // between the 16 and 8 fast limits
        wr(4'h0, 32'h15);                   // window mode on
        for (int i = 0; i < 4; i++) begin
            {selB, selA} <= ratios[i];
            strobeOn <= (ratios[i] != RATIO_OFF);
            repeat (200) @(posedge clk);
            levelCount(1'b0, 400, i == 0);
        end
        rd(4'h3, 32'h3);
        wr(4'h3, 32'h7);                    // status is read-only
        rd(4'h3, 32'h3);
        wr(4'h5, 32'h2);
        #1 cmpWord({31'h0, irq}, 32'h1);
        wr(4'h5, 32'h0);
        #1 cmpWord({31'h0, irq}, 32'h0);
        wr(4'h4, 32'h7);
        rd(4'h3, 32'h0);
        dogOffN <= 1'b0;
        wr(4'h0, 32'h5);
        supplyGood <= 1'b0;
        repeat (20) @(posedge clk);
        supplyGood <= 1'b1;
        runLen(1'b0, 40, 44);
        rd(4'h3, 32'h4);
        wr(4'h0, 32'h6);                    // pulse pin grounded
        repeat (4) @(posedge clk);
        levelCount(1'b1, 300, 1'b0);
        wr(4'h0, 32'h5);
        runLen(1'b0, 0, 44);
        onReq <= 1'b1;
        outIs(1'b1);
        holdN <= 1'b0;
        onReq <= 1'b0;
        outIs(1'b1);
        holdN <= 1'b1;
        outIs(1'b0);
        onReq <= 1'b1;
        outIs(1'b1);
        overTemp <= 1'b1;
        belowLowTemp <= 1'b0;
        outIs(1'b0);
        overTemp <= 1'b0;
        outIs(1'b0);
        belowLowTemp <= 1'b1;
        outIs(1'b1);
        onReq <= 1'b0;
        outIs(1'b0);
        conclude();
    end
endmodule : testbench

bind svw_supervisor svw_monitor mon_u (.clk(clk), .nrst(nrst), .supplyGood(supplyGood),
    .dogOffN(dogOffN), .regulatorOnRequest(regulatorOnRequest), .holdN(holdN),
    .overTemp(overTemp), .belowLowTemp(belowLowTemp), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .resetN(resetN), .primarySupplyOutput(primarySupplyOutput));
